// ===== verification/hpb_bridge_test.sv
/*
 * Self-checking bench for hpb_bridge.
 * Assumes the peer model resolves the PCI wires.
 */
`timescale 1ns/1ns
module hpb_bridge_test;
	import hpb_pkg::*;
	logic clk_in = 0, rst_b_in = 0, cyc = 0, we = 0, hreq = 0, hwe = 0;
	logic hcpu = 0, iserr = 0, serr_n = 1, ext = 0;
	logic hrun = 1, prun = 1, perr_n = 1, loc;
	logic [5:0] reqn = 6'h3f, gnt;
	logic [31:0] hrd;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 0, rdat, wdo, haddr = 0, hdata = 0, aout, pad, cap_ad;
	hpb_hub_cmd_t hcmd = HPB_IO;
	logic ack, done, abrt, fn, foe, aoe, dn, doe, nmi, smi_n, pfn, pdn;
	logic fd = 0, dd = 0;
	logic [3:0] cbe, cap_cbe;
	int fails = 0, cmp_count = 0, age = 0, dage = 0, s = 0;
	int nfr = 0, nd = 0;
	hpb_bridge i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
		.wb_dat_in(wdat), .wb_dat_out(wdo), .wb_ack_out(ack),
		.hub_clk_run_in(hrun), .pci_clk_run_in(prun), .hub_req_in(hreq),
		.hub_cmd_in(hcmd), .hub_we_in(hwe), .hub_cpu_in(hcpu),
		.hub_addr_in(haddr), .hub_data_in(hdata), .hub_done_out(done),
		.hub_local_out(loc), .hub_abort_out(abrt), .hub_rdata_out(hrd),
		.int_serr_in(iserr), .pci_frame_n_in(pfn), .pci_devsel_n_in(pdn),
		.pci_ad_in(pad), .pci_serr_n_in(serr_n), .pci_perr_n_in(perr_n),
		.pci_req_n_in(reqn), .pci_frame_n_out(fn), .pci_frame_oe_out(foe),
		.pci_ad_out(aout), .pci_ad_oe_out(aoe), .pci_cbe_n_out(cbe),
		.pci_devsel_n_out(dn), .pci_devsel_oe_out(doe), .pci_gnt_n_out(gnt),
		.nmi_out(nmi), .system_mgmt_interrupt_n_out(smi_n));
	hpb_peer i_peer (.clk_in(clk_in), .frame_n_in(fn), .frame_oe_in(foe),
		.ad_in(aout), .ad_oe_in(aoe), .devsel_n_in(dn), .devsel_oe_in(doe),
		.ext_claim_in(ext), .frame_n_out(pfn), .devsel_n_out(pdn),
		.ad_out(pad));
	initial forever #5 clk_in = ~clk_in;
	// Frame start and claim delay in clocks
	always @(posedge clk_in) begin
		fd <= foe;
		dd <= doe;
		age <= age + 1;
		if (foe && !fd) begin
			cap_cbe <= cbe;
			cap_ad <= aout;
			age <= 0;
			nfr <= nfr + 1;
		end
		if (doe && !dd)
			dage <= age;
		if (done)
			nd <= nd + 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		cyc <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_in); while (ack !== 1'b1);
		rdat = wdo;
		cyc <= 0;
	endtask
	task automatic hub(input hpb_hub_cmd_t c, input logic w, input logic cpu,
		input logic [31:0] a);
		@(posedge clk_in);
		hreq <= 1;
		hcmd <= c;
		hwe <= w;
		hcpu <= cpu;
		haddr <= a;
		hdata <= 32'h0;
		do @(posedge clk_in); while (done !== 1'b1);
		hreq <= 0;
	endtask
	task automatic pulse_err();
		@(posedge clk_in);
		iserr <= 1;
		serr_n <= 0;
		@(posedge clk_in);
		iserr <= 0;
		repeat (3) @(posedge clk_in);
		serr_n <= 1;
		repeat (6) @(posedge clk_in);
	endtask
	task automatic give_verdict();
		if (fails == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#300000;
		fails++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge clk_in);
		rst_b_in <= 1;
		repeat (3) @(posedge clk_in);
		wb(0, REG_CTRL, 0);
		chk(rdat, {28'h0, CTRL_RST});
		wb(0, REG_OWN_BASE, 0);
		chk(rdat, {16'h0, OWN_BASE_RST});
		wb(0, 8'h20, 0);
		chk(rdat, 32'h0);
		hub(HPB_CFG, 1, 1, 32'h0001_ff00);
		chk(cap_cbe, {28'h0, ~CMD_SPECIAL});
		hub(HPB_CFG, 0, 0, 32'h0001_2800);
		chk(cap_ad[31:16], 16'h0020);
		chk(abrt, 1'b1);
		wb(1, REG_OWN_BASE, 32'h1000);
		wb(1, REG_OWN_LIM, 32'h1000);
		hub(HPB_MEM, 0, 0, 32'h1000_0000);
		s = dage;
		wb(1, REG_CTRL, 0);
		hub(HPB_MEM, 0, 0, 32'h1000_0000);
		chk(s - dage, 6);
		chk(abrt, 1'b0);
		chk(hrd, ~32'h1000_0000);
		s = nfr;
		hub(HPB_IO, 1, 0, 32'h1000_0000);
		chk(loc, 1'b1);
		chk(nfr - s, 0);
		// Stopped hub clock must leave a pending request untaken
		hrun <= 0;
		repeat (3) @(posedge clk_in);
		s = nd;
		hreq <= 1;
		repeat (8) @(posedge clk_in);
		chk(nd - s, 0);
		hreq <= 0;
		hrun <= 1;
		s = nfr;
		hub(HPB_CFG, 0, 0, 32'h0000_f800);
		chk(nfr - s, 1);
		chk(abrt, 1'b0);
		prun <= 0;
		repeat (3) @(posedge clk_in);
		reqn <= 6'h3e;
		repeat (9) @(posedge clk_in);
		chk(gnt, 6'h3f);
		prun <= 1;
		repeat (9) @(posedge clk_in);
		chk(gnt, 6'h3e);
		reqn <= 6'h3f;
		repeat (9) @(posedge clk_in);
		chk(gnt, 6'h3f);
		wb(1, REG_CTRL, 32'h3);
		ext <= 1;
		hub(HPB_MEM, 0, 0, 32'hfff0_0000);
		ext <= 0;
		// Boot flag lands only at subtractive time, after the cycle ends
		repeat (PCI_DIV * SUB_TICKS) @(posedge clk_in);
		wb(0, REG_STAT, 0);
		chk(rdat[STB_BOOT], 1'b1);
		chk(rdat[STB_SHUT], 1'b1);
		pulse_err();
		chk(nmi, 1'b1);
		wb(1, REG_STAT, 32'hf);
		wb(1, REG_CTRL, 32'hb);
		pulse_err();
		chk({nmi, smi_n}, 2'b00);
		wb(1, REG_STAT, 32'hf);
		wb(1, REG_CTRL, 32'h5);
		perr_n <= 0;
		repeat (4) @(posedge clk_in);
		perr_n <= 1;
		repeat (6) @(posedge clk_in);
		chk({nmi, smi_n}, 2'b11);
		rst_b_in <= 0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1;
		repeat (3) @(posedge clk_in);
		chk({nmi, smi_n}, 2'b01);
		wb(0, REG_OWN_LIM, 0);
		chk(rdat, {16'h0, OWN_LIM_RST});
		give_verdict();
	end
endmodule

// ===== verification/hpb_peer.sv
/*
 * Far side of the PCI pins: wire resolution plus one external target.
 * Assumes bridge pin outputs as inputs; the bench raises ext_claim_in.
 */
`timescale 1ns/1ns
module hpb_peer (
	input  wire logic        clk_in,
	input  wire logic        frame_n_in,
	input  wire logic        frame_oe_in,
	input  wire logic [31:0] ad_in,
	input  wire logic        ad_oe_in,
	input  wire logic        devsel_n_in,
	input  wire logic        devsel_oe_in,
	input  wire logic        ext_claim_in,
	output logic             frame_n_out,
	output logic             devsel_n_out,
	output logic      [31:0] ad_out
);
	logic [31:0] last_r = 32'h0;
	logic [3:0]  age_r  = 4'h0;
	logic        ext;
	// Pull-ups hold released control lines high
	assign frame_n_out = frame_oe_in ? frame_n_in : 1'b1;
	// Positive claim well before subtractive time
	assign ext = ext_claim_in && age_r >= 4'h2 && age_r <= 4'h5;
	assign devsel_n_out = ~((devsel_oe_in & ~devsel_n_in) | ext);
	// Released AD shows no stale value
	assign ad_out = ad_oe_in ? ad_in : ~last_r;
	always_ff @(posedge clk_in) begin
		if (ad_oe_in)
			last_r <= ad_in;
		if (frame_oe_in && !frame_n_in)
			age_r <= 4'h1;
		else if (age_r != 4'h0 && age_r != 4'hf)
			age_r <= age_r + 4'h1;
	end
endmodule

// ===== verilog/hpb_arbiter.sv
/*
 * Round-robin PCI arbiter; index 0 is the bridge's own master.
 * Assumes requests are already synchronised and active high.
 */
`timescale 1ns/1ns
module hpb_arbiter #(
	parameter int N = 7
) (
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	input  wire logic         tick_in,
	input  wire logic [N-1:0] req_in,
	output logic      [N-1:0] gnt_n_out
);
	import hpb_pkg::*;
	localparam int W = $clog2(N);
	logic [W-1:0] last_r;
	logic [W-1:0] win;
	logic         found;
	logic         held;

	always_comb begin
		win = last_r;
		found = 1'b0;
		for (int i = 1; i <= N; i++) begin
			if (!found && req_in[(int'(last_r) + i) % N]) begin
				win = W'((int'(last_r) + i) % N);
				found = 1'b1;
			end
		end
	end

	// Grant moves only once the holder lets go of its request
	assign held = |(~gnt_n_out & req_in);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gnt_n_out <= '1;
			last_r <= '0;
		end else if (tick_in && !held) begin
			gnt_n_out <= found ? ~(N'(1) << win) : '1;
			if (found) begin
				last_r <= win;
			end
		end
	end

	a_gnt_one_holder: assert property (@(posedge clk_in)
		disable iff (!rst_b_in) $onehot0(~gnt_n_out))
		else $error("more than one grant active");
endmodule

// ===== verilog/hpb_bridge.sv
/*
 * Hub-link to PCI bridge: cycle routing, claim timing, special cycle,
 * IDSEL, arbitration and error routing, with a Wishbone register slave.
 * Assumes PCI pins are resolved outside; every pin input is synchronised.
 */
`timescale 1ns/1ns
module hpb_bridge #(
	parameter bit LARGE = 1'b1,
	parameter int N_EXT = 6
) (
	input  wire logic                 clk_in,
	input  wire logic                 rst_b_in,
	input  wire logic                 wb_cyc_in,
	input  wire logic                 wb_stb_in,
	input  wire logic                 wb_we_in,
	input  wire logic [7:0]           wb_adr_in,
	input  wire logic [3:0]           wb_sel_in,
	input  wire logic [31:0]          wb_dat_in,
	output logic      [31:0]          wb_dat_out,
	output logic                      wb_ack_out,
	input  wire logic                 hub_clk_run_in,
	input  wire logic                 pci_clk_run_in,
	input  wire logic                 hub_req_in,
	input  wire hpb_pkg::hpb_hub_cmd_t hub_cmd_in,
	input  wire logic                 hub_we_in,
	input  wire logic                 hub_cpu_in,
	input  wire logic [31:0]          hub_addr_in,
	input  wire logic [31:0]          hub_data_in,
	output logic                      hub_done_out,
	output logic                      hub_local_out,
	output logic                      hub_abort_out,
	output logic      [31:0]          hub_rdata_out,
	input  wire logic                 int_serr_in,
	input  wire logic                 pci_frame_n_in,
	input  wire logic                 pci_devsel_n_in,
	input  wire logic [31:0]          pci_ad_in,
	input  wire logic                 pci_serr_n_in,
	input  wire logic                 pci_perr_n_in,
	input  wire logic [N_EXT-1:0]     pci_req_n_in,
	output logic                      pci_frame_n_out,
	output logic                      pci_frame_oe_out,
	output logic      [31:0]          pci_ad_out,
	output logic                      pci_ad_oe_out,
	output logic      [3:0]           pci_cbe_n_out,
	output logic                      pci_devsel_n_out,
	output logic                      pci_devsel_oe_out,
	output logic      [N_EXT-1:0]     pci_gnt_n_out,
	output logic                      nmi_out,
	output logic                      system_mgmt_interrupt_n_out
);
	import hpb_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	localparam int SW = 38 + N_EXT;
	logic [SW-1:0] pin_s1_r;
	logic [SW-1:0] pin_s2_r;
	logic [31:0]   ad_s;
	logic [N_EXT-1:0] req_n_s;
	logic          frame_s;
	logic          devsel_s;
	logic          serr_s;
	logic          perr_s;
	logic          hub_run_s;
	logic          pci_run_s;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_s1_r <= '1;
			pin_s2_r <= '1;
		end else begin
			pin_s1_r <= {pci_ad_in, pci_req_n_in, pci_frame_n_in,
				pci_devsel_n_in, pci_serr_n_in, pci_perr_n_in,
				hub_clk_run_in, pci_clk_run_in};
			pin_s2_r <= pin_s1_r;
		end
	end
	assign {ad_s, req_n_s, frame_s, devsel_s, serr_s, perr_s,
		hub_run_s, pci_run_s} = pin_s2_r;

	// ****************************************************************
	// PCI rate divider
	// ****************************************************************
	logic [1:0] div_r;
	logic       pci_tick;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_r <= 2'h0;
		end else if (pci_run_s) begin
			div_r <= (div_r == 2'(PCI_DIV - 1)) ? 2'h0 : div_r + 2'h1;
		end
	end
	assign pci_tick = pci_run_s && (div_r == 2'h0);

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [3:0]  ctrl_r;
	logic [7:0]  secbus_r;
	logic [15:0] own_base_r;
	logic [15:0] own_lim_r;
	logic [3:0]  stat_r;
	logic [3:0]  stat_set;
	logic [31:0] wmask;
	logic [31:0] rd_data;
	logic        wb_go;
	logic        wb_wr;
	logic        ack_r;

	assign wb_go = wb_cyc_in && wb_stb_in && !ack_r;
	assign wb_wr = wb_go && wb_we_in;
	assign wmask = hpb_wmask(wb_sel_in);

	always_comb begin
		case (wb_adr_in)
		REG_CTRL:     rd_data = {28'h0, ctrl_r};
		REG_SECBUS:   rd_data = {24'h0, secbus_r};
		REG_OWN_BASE: rd_data = {16'h0, own_base_r};
		REG_OWN_LIM:  rd_data = {16'h0, own_lim_r};
		REG_STAT:     rd_data = {28'h0, stat_r};
		default:      rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack_r <= 1'b0;
			wb_dat_out <= 32'h0;
		end else begin
			ack_r <= wb_go;
			if (wb_go) begin
				wb_dat_out <= rd_data;
			end
		end
	end
	assign wb_ack_out = ack_r;

	// All registers load their reset values on the core-power reset
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_r <= CTRL_RST;
			secbus_r <= SECBUS_RST;
			own_base_r <= OWN_BASE_RST;
			own_lim_r <= OWN_LIM_RST;
		end else if (wb_wr) begin
			case (wb_adr_in)
			REG_CTRL: ctrl_r <= (ctrl_r & ~wmask[3:0])
				| (wb_dat_in[3:0] & wmask[3:0]);
			REG_SECBUS: secbus_r <= (secbus_r & ~wmask[7:0])
				| (wb_dat_in[7:0] & wmask[7:0]);
			REG_OWN_BASE: own_base_r <= (own_base_r & ~wmask[15:0])
				| (wb_dat_in[15:0] & wmask[15:0]);
			REG_OWN_LIM: own_lim_r <= (own_lim_r & ~wmask[15:0])
				| (wb_dat_in[15:0] & wmask[15:0]);
			default: ctrl_r <= ctrl_r;
			endcase
		end
	end

	// Write one to clear; a fresh event in the same cycle wins
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stat_r <= 4'h0;
		end else begin
			stat_r <= (stat_r & ~((wb_wr && wb_adr_in == REG_STAT)
				? (wb_dat_in[3:0] & wmask[3:0]) : 4'h0)) | stat_set;
		end
	end

	// ****************************************************************
	// Error sources
	// ****************************************************************
	logic serr_d_r;
	logic perr_d_r;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			serr_d_r <= 1'b1;
			perr_d_r <= 1'b1;
		end else begin
			serr_d_r <= serr_s;
			perr_d_r <= perr_s;
		end
	end
	// The system error pin is only ever sampled, never driven
	assign stat_set[STB_SERR] = int_serr_in || (serr_d_r && !serr_s);
	assign stat_set[STB_PERR] = LARGE && perr_d_r && !perr_s;

	hpb_err_route #(
		.HAS_PERR(LARGE)
	) u_err (
		.clk_in     (clk_in),
		.rst_b_in   (rst_b_in),
		.serr_sts_in(stat_r[STB_SERR]),
		.perr_sts_in(stat_r[STB_PERR]),
		.serr_en_in (ctrl_r[CTL_SERR_EN]),
		.perr_en_in (ctrl_r[CTL_PERR_EN]),
		.to_smi_in  (ctrl_r[CTL_TO_SMI]),
		.nmi_out    (nmi_out),
		.smi_n_out  (system_mgmt_interrupt_n_out)
	);

	// ****************************************************************
	// Hub request classification
	// ****************************************************************
	logic [7:0]  h_bus;
	logic [4:0]  h_dev;
	logic        is_shut;
	logic        go_local;
	logic        cfg_int;
	logic        cfg_sec;
	logic        cfg_bad;
	logic [31:0] ad_nxt;
	logic [3:0]  cmd_nxt;

	assign h_bus = hub_addr_in[23:16];
	assign h_dev = hub_addr_in[15:11];
	assign is_shut = hub_cmd_in == HPB_CFG && hub_we_in && hub_cpu_in
		&& h_dev == SHUT_DEV && hub_addr_in[10:8] == SHUT_FN
		&& hub_addr_in[7:2] == SHUT_REG && hub_data_in[7:0] == SHUT_DATA
		&& h_bus == secbus_r;
	assign go_local = hub_cmd_in == HPB_IO
		&& hpb_own_hit(hub_addr_in, own_base_r, own_lim_r);
	assign cfg_int = hub_cmd_in == HPB_CFG && h_bus == HUB_BUS;
	assign cfg_sec = hub_cmd_in == HPB_CFG && h_bus == secbus_r;
	// Only sixteen IDSEL lines exist on the external bus
	assign cfg_bad = cfg_sec && h_dev[4] && !is_shut;

	always_comb begin
		if (cfg_int) begin
			ad_nxt = {16'h0, hub_addr_in[15:2], 2'b00};
		end else if (cfg_sec) begin
			ad_nxt = hpb_idsel(h_dev[3:0])
				| {21'h0, hub_addr_in[10:2], 2'b00};
		end else if (hub_cmd_in == HPB_CFG) begin
			ad_nxt = {8'h0, hub_addr_in[23:2], 2'b01};
		end else begin
			ad_nxt = hub_addr_in;
		end
		case (hub_cmd_in)
		HPB_IO:  cmd_nxt = hub_we_in ? CMD_IO_WR : CMD_IO_RD;
		HPB_MEM: cmd_nxt = hub_we_in ? CMD_MEM_WR : CMD_MEM_RD;
		HPB_CFG: cmd_nxt = hub_we_in ? CMD_CFG_WR : CMD_CFG_RD;
		default: cmd_nxt = CMD_MEM_RD;
		endcase
		if (is_shut) begin
			cmd_nxt = CMD_SPECIAL;
		end
	end

	// ****************************************************************
	// Master sequencer
	// ****************************************************************
	hpb_state_t  st_r;
	logic [31:0] mas_ad_r;
	logic [31:0] mas_dat_r;
	logic [3:0]  mas_cmd_r;
	logic        mas_we_r;
	logic        mas_shut_r;
	logic        mas_int_r;
	logic [2:0]  wait_r;
	logic        fr_n_r;
	logic        fr_oe_r;
	logic [31:0] ad_r;
	logic        ad_oe_r;
	logic [3:0]  cbe_n_r;
	logic        done_r;
	logic        local_r;
	logic        abort_r;
	logic [31:0] rdat_r;
	logic        dv_n_r;
	logic        dv_oe_r;
	logic        claimed;
	logic [N_EXT:0] gnt_n;

	assign claimed = !devsel_s || dv_oe_r;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= S_IDLE;
			{mas_ad_r, mas_dat_r, mas_cmd_r} <= '0;
			{mas_we_r, mas_shut_r, mas_int_r} <= 3'h0;
			wait_r <= 3'h0;
			fr_n_r <= 1'b1;
			fr_oe_r <= 1'b0;
			ad_r <= 32'h0;
			ad_oe_r <= 1'b0;
			cbe_n_r <= 4'hf;
			{done_r, local_r, abort_r} <= 3'h0;
			rdat_r <= 32'h0;
		end else begin
			done_r <= 1'b0;
			if (hub_run_s) begin
				case (st_r)
				S_IDLE: if (hub_req_in) begin
					if (go_local || cfg_bad) begin
						st_r <= S_DONE;
						done_r <= 1'b1;
						local_r <= go_local;
						abort_r <= cfg_bad;
					end else begin
						st_r <= S_ARB;
						mas_ad_r <= ad_nxt;
						mas_dat_r <= hub_data_in;
						mas_cmd_r <= cmd_nxt;
						mas_we_r <= hub_we_in;
						mas_shut_r <= is_shut;
						mas_int_r <= cfg_int;
					end
				end
				S_ARB: if (pci_tick && !gnt_n[0]) begin
					st_r <= S_ADDR;
					fr_n_r <= 1'b0;
					fr_oe_r <= 1'b1;
					ad_r <= mas_ad_r;
					ad_oe_r <= 1'b1;
					cbe_n_r <= ~mas_cmd_r;
				end
				S_ADDR: if (pci_tick) begin
					st_r <= S_DATA;
					fr_n_r <= 1'b1;
					cbe_n_r <= 4'h0;
					ad_r <= mas_shut_r ? {16'h0, SHUT_MSG} : mas_dat_r;
					ad_oe_r <= mas_we_r;
					wait_r <= 3'h0;
				end
				S_DATA: if (pci_tick) begin
					fr_oe_r <= 1'b0;
					wait_r <= wait_r + 3'h1;
					// Special cycles have no target to answer them
					if (mas_shut_r || claimed || wait_r == ABORT_TICKS) begin
						st_r <= S_DONE;
						done_r <= 1'b1;
						local_r <= 1'b0;
						abort_r <= !mas_shut_r && !claimed;
						rdat_r <= ad_s;
						ad_oe_r <= 1'b0;
						cbe_n_r <= 4'hf;
					end
				end
				S_DONE: st_r <= S_IDLE;
				default: st_r <= S_IDLE;
				endcase
			end
		end
	end
	assign stat_set[STB_SHUT] = done_r && mas_shut_r && !local_r;

	assign hub_done_out = done_r;
	assign hub_local_out = local_r;
	assign hub_abort_out = abort_r;
	assign hub_rdata_out = rdat_r;
	assign pci_frame_n_out = fr_n_r;
	assign pci_frame_oe_out = fr_oe_r;
	assign pci_ad_out = ad_r;
	assign pci_ad_oe_out = ad_oe_r;
	assign pci_cbe_n_out = cbe_n_r;
	assign pci_gnt_n_out = gnt_n[N_EXT:1];

	hpb_arbiter #(
		.N(N_EXT + 1)
	) u_arb (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.tick_in  (pci_tick),
		.req_in   ({~req_n_s, st_r == S_ARB || st_r == S_ADDR}),
		.gnt_n_out(gnt_n)
	);

	// ****************************************************************
	// Target claim
	// ****************************************************************
	logic        frame_d_r;
	logic [2:0]  tgt_cnt_r;
	logic [31:0] tgt_addr_r;
	logic        tgt_sub_r;
	logic        tgt_hit_r;
	logic        ext_seen_r;
	logic        claim_now;

	assign claim_now = tgt_hit_r && (tgt_sub_r
		? (tgt_cnt_r == SUB_TICKS && !ext_seen_r)
		: tgt_cnt_r == MED_TICKS);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			frame_d_r <= 1'b1;
			tgt_cnt_r <= 3'h0;
			tgt_addr_r <= 32'h0;
			{tgt_sub_r, tgt_hit_r, ext_seen_r} <= 3'h0;
			dv_n_r <= 1'b1;
			dv_oe_r <= 1'b0;
		end else if (pci_tick) begin
			frame_d_r <= frame_s;
			dv_n_r <= !claim_now;
			dv_oe_r <= claim_now;
			if (frame_d_r && !frame_s) begin
				tgt_cnt_r <= 3'h1;
				tgt_addr_r <= ad_s;
				tgt_sub_r <= ctrl_r[CTL_SUBTR];
				tgt_hit_r <= hpb_own_hit(ad_s, own_base_r, own_lim_r)
					|| (mas_int_r && st_r != S_IDLE);
				ext_seen_r <= 1'b0;
			end else begin
				tgt_cnt_r <= (tgt_cnt_r != 3'h0 && tgt_cnt_r < ABORT_TICKS)
					? tgt_cnt_r + 3'h1 : 3'h0;
				if (tgt_cnt_r != 3'h0 && !devsel_s && !dv_oe_r) begin
					ext_seen_r <= 1'b1;
				end
			end
		end
	end
	assign pci_devsel_n_out = dv_n_r;
	assign pci_devsel_oe_out = dv_oe_r;
	// Boot code served by a card that won the claim ahead of us
	assign stat_set[STB_BOOT] = pci_tick && tgt_cnt_r == SUB_TICKS
		&& tgt_sub_r && ext_seen_r && tgt_addr_r[31:20] == BOOT_HI;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_ack_one_cycle: assert property (@(posedge clk_in)
		disable iff (!rst_b_in) wb_ack_out |=> !wb_ack_out)
		else $error("bus ack held too long");
	a_local_io_quiet: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		(st_r == S_IDLE && hub_run_s && hub_req_in && go_local)
		|=> hub_done_out && hub_local_out && !pci_frame_oe_out)
		else $error("local io reached the pci bus");
	a_med_claim: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		(pci_tick && claim_now && !tgt_sub_r)
		|-> tgt_cnt_r == MED_TICKS ##1 !pci_devsel_n_out)
		else $error("positive claim at wrong time");
	a_sub_claim: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		$rose(pci_devsel_oe_out) && $past(tgt_sub_r)
		|-> $past(tgt_cnt_r) == SUB_TICKS && !$past(ext_seen_r))
		else $error("subtractive claim early or contested");
	a_shut_cmd: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		$fell(pci_frame_n_out) && pci_cbe_n_out == ~CMD_SPECIAL
		|-> mas_shut_r)
		else $error("special cycle without shutdown match");
	a_idsel_one: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		$fell(pci_frame_n_out) && pci_ad_out[1:0] == 2'b00
		&& !mas_int_r && mas_cmd_r[3:1] == 3'h5
		|-> $onehot(pci_ad_out[31:16]))
		else $error("idsel not one hot");
	a_boot_sticky: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		stat_r[STB_BOOT] && !(wb_wr && wb_adr_in == REG_STAT)
		|=> stat_r[STB_BOOT])
		else $error("boot flag lost without clear");
	a_serr_sets: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		int_serr_in |=> stat_r[STB_SERR] ##1 (nmi_out
		|| !system_mgmt_interrupt_n_out || !ctrl_r[CTL_SERR_EN]))
		else $error("system error not reported");
endmodule

// ===== verilog/hpb_err_route.sv
/*
 * Routes sticky error status to the NMI or the system-management line.
 * Assumes status and enables come from registers on the same clock.
 */
`timescale 1ns/1ns
module hpb_err_route #(
	parameter bit HAS_PERR = 1'b1
) (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic serr_sts_in,
	input  wire logic perr_sts_in,
	input  wire logic serr_en_in,
	input  wire logic perr_en_in,
	input  wire logic to_smi_in,
	output logic      nmi_out,
	output logic      smi_n_out
);
	logic cause;

	// Parity reporting exists only on the larger variant
	assign cause = (serr_sts_in && serr_en_in) ||
		(HAS_PERR && perr_sts_in && perr_en_in);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			nmi_out <= 1'b0;
			smi_n_out <= 1'b1;
		end else begin
			nmi_out <= cause && !to_smi_in;
			smi_n_out <= !(cause && to_smi_in);
		end
	end

	a_nmi_smi_excl: assert property (@(posedge clk_in)
		disable iff (!rst_b_in) !(nmi_out && !smi_n_out))
		else $error("nmi and smi raised together");
	a_smi_follows: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		(cause && to_smi_in) |=> !smi_n_out && !nmi_out)
		else $error("rerouted event did not reach smi");
endmodule

// ===== verilog/hpb_pkg.sv
/*
 * Constants, types and helpers shared by the hub-to-PCI bridge.
 * Assumes a 100 MHz system clock; the PCI rate is an enable pulse.
 */
package hpb_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ  = 100_000_000;
	localparam int PCI_HZ  = 33_000_000;
	localparam int PCI_DIV = CLK_HZ / PCI_HZ;
	localparam int HUB_HZ  = 66_000_000;
	localparam int N_EXT_LARGE = 6;
	localparam int N_EXT_SMALL = 4;
	localparam logic [2:0] MED_TICKS   = 3'h2;
	localparam logic [2:0] SUB_TICKS   = 3'h4;
	localparam logic [2:0] ABORT_TICKS = 3'h5;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_SECBUS   = 8'h04;
	localparam logic [7:0] REG_OWN_BASE = 8'h08;
	localparam logic [7:0] REG_OWN_LIM  = 8'h0c;
	localparam logic [7:0] REG_STAT     = 8'h10;
	localparam int CTL_SUBTR   = 0;
	localparam int CTL_SERR_EN = 1;
	localparam int CTL_PERR_EN = 2;
	localparam int CTL_TO_SMI  = 3;
	localparam int STB_SERR    = 0;
	localparam int STB_PERR    = 1;
	localparam int STB_BOOT    = 2;
	localparam int STB_SHUT    = 3;
	localparam logic [3:0]  CTRL_RST     = 4'h1;
	localparam logic [7:0]  SECBUS_RST   = 8'h01;
	localparam logic [15:0] OWN_BASE_RST = 16'hffff;
	localparam logic [15:0] OWN_LIM_RST  = 16'h0000;

	// ****************************************************************
	// Bus encodings
	// ****************************************************************
	localparam logic [3:0] CMD_SPECIAL = 4'h1;
	localparam logic [3:0] CMD_IO_RD   = 4'h2;
	localparam logic [3:0] CMD_IO_WR   = 4'h3;
	localparam logic [3:0] CMD_MEM_RD  = 4'h6;
	localparam logic [3:0] CMD_MEM_WR  = 4'h7;
	localparam logic [3:0] CMD_CFG_RD  = 4'ha;
	localparam logic [3:0] CMD_CFG_WR  = 4'hb;
	localparam logic [4:0] SHUT_DEV  = 5'h1f;
	localparam logic [2:0] SHUT_FN   = 3'h7;
	localparam logic [5:0] SHUT_REG  = 6'h00;
	localparam logic [7:0] SHUT_DATA = 8'h00;
	localparam logic [15:0] SHUT_MSG = 16'h0000;
	localparam logic [7:0] HUB_BUS   = 8'h00;
	localparam logic [11:0] BOOT_HI  = 12'hfff;

	typedef enum logic [1:0] {
		HPB_IO  = 2'h0,
		HPB_MEM = 2'h1,
		HPB_CFG = 2'h2
	} hpb_hub_cmd_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ARB  = 3'h1,
		S_ADDR = 3'h3,
		S_DATA = 3'h2,
		S_DONE = 3'h6
	} hpb_state_t;

	function automatic logic [31:0] hpb_idsel(input logic [3:0] dev);
		hpb_idsel = 32'h0001_0000 << dev;
	endfunction

	function automatic logic hpb_own_hit(input logic [31:0] a,
		input logic [15:0] base, input logic [15:0] lim);
		hpb_own_hit = (a[31:16] >= base) && (a[31:16] <= lim);
	endfunction

	function automatic logic [31:0] hpb_wmask(input logic [3:0] sel);
		hpb_wmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction
endpackage
